// ===== design/two_wire_map.svh
// Write mask, field positions, reset values and timing counts of the two-wire port
`ifndef TWO_WIRE_MAP_SVH
`define TWO_WIRE_MAP_SVH
`define STAT_WR_MASK      8'hC0
`define CTRL_A_RST        8'h00
`define CTRL_B_RST        8'h00
`define STAT_RST          8'h00
`define ADDR_RST          8'h00
`define CTRL_A_EN_BIT     5
`define CTRL_A_MASTER_BIT 3
`define CTRL_B_SEN_BIT    0
`define CTRL_B_PEN_BIT    2
`define CTRL_B_ACKDT_BIT  5
`define CTRL_B_GCEN_BIT   7
`define STAT_STOP_BIT     4
`define STAT_START_BIT    3
`define STAT_RW_BIT       2
`define STAT_BF_BIT       0
`define STAT_DA_BIT       5
`define RELOAD_MSB        6
`define QUARTERS          2'h3
`define ADDR10_HDR        5'h1E
`endif

// ===== design/two_wire_pkg.sv
// Types of the two-wire port
package two_wire_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_LOW   = 3'b010,
        ST_HIGH  = 3'b011,
        ST_STOP  = 3'b100,
        ST_DONE  = 3'b101
    } mst_state_e;
endpackage

// ===== design/two_wire_port.sv
// Two-wire serial port with master bit clock and slave address match
`timescale 1ns/1ps
`include "two_wire_map.svh"
module two_wire_port (
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       reset_i,
    // Software register access
    input  wire logic [7:0] wr_data_i,
    input  wire logic       ctrl_a_wr_i,
    input  wire logic       ctrl_b_wr_i,
    input  wire logic       status_wr_i,
    input  wire logic       buffer_wr_i,
    input  wire logic       addr_wr_i,
    input  wire logic       buffer_rd_i,
    input  wire logic       irq_clr_i,
    output logic      [7:0] serial_ctrl_a_o,
    output logic      [7:0] serial_ctrl_b_o,
    output logic      [7:0] serial_status_reg_o,
    output logic      [7:0] serial_byte_buffer_o,
    output logic      [7:0] own_addr_or_reload_o,
    output logic            serial_irq_flag_o,
    // Bus pins
    input  wire logic       bus_clock_pin_i,
    output logic            bus_clock_pin_o,
    output logic            bus_clock_pin_oe_o,
    input  wire logic       bus_data_pin_i,
    output logic            bus_data_pin_o,
    output logic            bus_data_pin_oe_o
);
    logic [7:0] ctrl_a_q, ctrl_b_q, stat_q, buf_q, addr_q, shift_q;
    logic       irq_q;
    logic [1:0] quarter_q;
    logic       tick;
    logic [6:0] brg_q;
    logic       brg_load, brg_zero;
    logic [3:0] bit_q, sbit_q;
    logic       scl_low_q, sda_low_q, scl_d1_q, sda_d1_q;
    logic       master, enable;
    logic       start_seen, stop_seen, scl_rise;
    logic [1:0] sphase_q;
    logic       s_ack_q, s_rx_done;
    two_wire_pkg::mst_state_e st_q;

    assign enable = ctrl_a_q[`CTRL_A_EN_BIT];
    assign master = ctrl_a_q[`CTRL_A_MASTER_BIT];

    // Quarter-phase sequencer; ticks on phase two and four
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            quarter_q <= 2'h0;
        end else begin
            quarter_q <= quarter_q + 2'h1;
        end
    end
    assign tick = quarter_q[0];

    // Bit rate counter
    assign brg_zero = (brg_q == 7'h00);
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            brg_q <= 7'h00;
        end else if (brg_load) begin
            brg_q <= addr_q[`RELOAD_MSB:0];
        end else if (tick && !brg_zero) begin
            brg_q <= brg_q - 7'h01;
        end
    end

    // Master state machine: start, eight bits plus ack, stop
    always_comb begin
        brg_load = 1'b0;
        if (master && enable && buffer_wr_i && st_q == two_wire_pkg::ST_IDLE) begin
            brg_load = 1'b1;
        end else if (tick && brg_zero && st_q != two_wire_pkg::ST_IDLE &&
                     st_q != two_wire_pkg::ST_DONE) begin
            brg_load = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            st_q      <= two_wire_pkg::ST_IDLE;
            bit_q     <= 4'h0;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
        end else if (!enable || !master) begin
            st_q      <= two_wire_pkg::ST_IDLE;
            scl_low_q <= 1'b0;
            sda_low_q <= s_ack_q && sbit_q != 4'h8;
        end else begin
            case (st_q)
                two_wire_pkg::ST_IDLE: begin
                    if (buffer_wr_i) begin
                        st_q      <= two_wire_pkg::ST_START;
                        sda_low_q <= 1'b1;
                        bit_q     <= 4'h0;
                    end
                end
                two_wire_pkg::ST_START: begin
                    if (tick && brg_zero) begin
                        scl_low_q <= 1'b1;
                        sda_low_q <= ~shift_q[7];
                        st_q      <= two_wire_pkg::ST_LOW;
                    end
                end
                two_wire_pkg::ST_LOW: begin
                    if (tick && brg_zero) begin
                        scl_low_q <= 1'b0;
                        st_q      <= two_wire_pkg::ST_HIGH;
                    end
                end
                two_wire_pkg::ST_HIGH: begin
                    if (tick && brg_zero) begin
                        scl_low_q <= 1'b1;
                        bit_q     <= bit_q + 4'h1;
                        if (bit_q == 4'h8) begin
                            sda_low_q <= 1'b1;
                            st_q      <= two_wire_pkg::ST_STOP;
                        end else begin
                            sda_low_q <= (bit_q == 4'h7) ? 1'b0
                                         : ~shift_q[6 - bit_q[2:0]];
                            st_q      <= two_wire_pkg::ST_LOW;
                        end
                    end
                end
                two_wire_pkg::ST_STOP: begin
                    if (tick && brg_zero) begin
                        if (scl_low_q) begin
                            scl_low_q <= 1'b0;
                        end else begin
                            sda_low_q <= 1'b0;
                            st_q      <= two_wire_pkg::ST_DONE;
                        end
                    end
                end
                two_wire_pkg::ST_DONE: begin
                    st_q <= two_wire_pkg::ST_IDLE;
                end
                default: st_q <= two_wire_pkg::ST_IDLE;
            endcase
        end
    end

    // Bus condition detection
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            scl_d1_q <= 1'b1;
            sda_d1_q <= 1'b1;
        end else begin
            scl_d1_q <= bus_clock_pin_i;
            sda_d1_q <= bus_data_pin_i;
        end
    end
    assign start_seen = scl_d1_q && bus_clock_pin_i && sda_d1_q && !bus_data_pin_i;
    assign stop_seen  = scl_d1_q && bus_clock_pin_i && !sda_d1_q && bus_data_pin_i;
    assign scl_rise   = !scl_d1_q && bus_clock_pin_i;

    // Slave receiver: address match (7-bit, general call, 10-bit header only; second 10-bit byte acked unchecked) then data
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            sbit_q   <= 4'h0;
            sphase_q <= 2'h0;
            s_ack_q  <= 1'b0;
            shift_q  <= 8'h00;
        end else if (buffer_wr_i) begin
            shift_q <= wr_data_i;
        end else if (start_seen || stop_seen || !enable) begin
            sbit_q   <= 4'h0;
            sphase_q <= (start_seen && enable) ? 2'h1 : 2'h0;
            s_ack_q  <= 1'b0;
        end else if (scl_d1_q && !bus_clock_pin_i) begin
            sbit_q  <= (sbit_q == 4'h8) ? 4'h9 : sbit_q;
            s_ack_q <= s_ack_q && sbit_q != 4'h0;
        end else if (!master && sphase_q != 2'h0 && scl_rise) begin
            if (sbit_q[3]) begin
                sbit_q  <= 4'h0;
            end else begin
                shift_q <= {shift_q[6:0], bus_data_pin_i};
                sbit_q  <= sbit_q + 4'h1;
                if (sbit_q == 4'h7) begin
                    if (sphase_q == 2'h1) begin
                        if ((shift_q[6:0] == addr_q[7:1]) ||
                            (shift_q[6:0] == 7'h00 &&
                             ctrl_b_q[`CTRL_B_GCEN_BIT])) begin
                            s_ack_q  <= 1'b1;
                            sphase_q <= 2'h3;
                        end else if (shift_q[6:2] == `ADDR10_HDR &&
                                     shift_q[1:0] == addr_q[2:1]) begin
                            s_ack_q  <= 1'b1;
                            sphase_q <= 2'h2;
                        end else begin
                            sphase_q <= 2'h0;
                        end
                    end else if (sphase_q == 2'h2) begin
                        s_ack_q  <= 1'b1;
                        sphase_q <= 2'h3;
                    end else begin
                        s_ack_q <= ~ctrl_b_q[`CTRL_B_ACKDT_BIT];
                    end
                end
            end
        end
    end
    assign s_rx_done = !master && sphase_q == 2'h3 && scl_rise && sbit_q == 4'h7;

    // Software registers
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            ctrl_a_q <= `CTRL_A_RST;
            ctrl_b_q <= `CTRL_B_RST;
            addr_q   <= `ADDR_RST;
        end else begin
            if (ctrl_a_wr_i) ctrl_a_q <= wr_data_i;
            if (ctrl_b_wr_i) ctrl_b_q <= wr_data_i;
            if (addr_wr_i)   addr_q   <= wr_data_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            buf_q <= 8'h00;
            stat_q <= `STAT_RST;
            irq_q  <= 1'b0;
        end else begin
            if (buffer_wr_i) begin
                buf_q <= wr_data_i;
            end else if (s_rx_done) begin
                buf_q <= {shift_q[6:0], bus_data_pin_i};
            end
            if (status_wr_i) begin
                stat_q[7:6] <= wr_data_i[7:6];
            end
            if (start_seen) begin
                stat_q[`STAT_START_BIT] <= 1'b1;
                stat_q[`STAT_STOP_BIT]  <= 1'b0;
            end else if (stop_seen) begin
                stat_q[`STAT_STOP_BIT]  <= 1'b1;
                stat_q[`STAT_START_BIT] <= 1'b0;
            end
            if (s_rx_done) begin
                stat_q[`STAT_BF_BIT] <= 1'b1;
            end else if (buffer_rd_i) begin
                stat_q[`STAT_BF_BIT] <= 1'b0;
            end
            stat_q[`STAT_RW_BIT] <= st_q != two_wire_pkg::ST_IDLE;
            if (s_rx_done || start_seen || stop_seen ||
                st_q == two_wire_pkg::ST_DONE) begin
                irq_q <= 1'b1;
            end else if (irq_clr_i) begin
                irq_q <= 1'b0;
            end
        end
    end

    // Registered outputs; pins only pull low
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            serial_ctrl_a_o      <= `CTRL_A_RST;
            serial_ctrl_b_o      <= `CTRL_B_RST;
            serial_status_reg_o  <= `STAT_RST;
            serial_byte_buffer_o <= 8'h00;
            own_addr_or_reload_o <= `ADDR_RST;
            serial_irq_flag_o    <= 1'b0;
            bus_clock_pin_o      <= 1'b0;
            bus_clock_pin_oe_o   <= 1'b0;
            bus_data_pin_o       <= 1'b0;
            bus_data_pin_oe_o    <= 1'b0;
        end else begin
            serial_ctrl_a_o      <= ctrl_a_q;
            serial_ctrl_b_o      <= ctrl_b_q;
            serial_status_reg_o  <= stat_q;
            serial_byte_buffer_o <= buf_q;
            own_addr_or_reload_o <= addr_q;
            serial_irq_flag_o    <= irq_q;
            bus_clock_pin_o      <= 1'b0;
            bus_clock_pin_oe_o   <= enable && scl_low_q;
            bus_data_pin_o       <= 1'b0;
            bus_data_pin_oe_o    <= enable && sda_low_q;
        end
    end
endmodule

// ===== bench/two_wire_port_assertions.sv
// Concurrent checks on the two-wire port pins and register mirrors
`timescale 1ns/1ps
module two_wire_port_assertions (
    // Clock, reset and software strobes
    input wire logic       sys_clk_i,
    input wire logic       reset_i,
    input wire logic [7:0] wr_data_i,
    input wire logic       ctrl_a_wr_i,
    input wire logic       ctrl_b_wr_i,
    input wire logic       status_wr_i,
    input wire logic       buffer_wr_i,
    input wire logic       addr_wr_i,
    input wire logic       irq_clr_i,
    // Register mirrors
    input wire logic [7:0] serial_ctrl_a_o,
    input wire logic [7:0] serial_ctrl_b_o,
    input wire logic [7:0] serial_status_reg_o,
    input wire logic [7:0] serial_byte_buffer_o,
    input wire logic [7:0] own_addr_or_reload_o,
    input wire logic       serial_irq_flag_o,
    // Bus pins
    input wire logic       bus_clock_pin_o,
    input wire logic       bus_clock_pin_oe_o,
    input wire logic       bus_data_pin_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    a_pins_only_low:
    assert property (!bus_clock_pin_o && !bus_data_pin_o)
        else $error("pin drives a high level");
    a_ctrl_a_rw:
    assert property (ctrl_a_wr_i |-> ##2 serial_ctrl_a_o == $past(wr_data_i, 2))
        else $error("control a mirror wrong");
    a_ctrl_b_rw:
    assert property (ctrl_b_wr_i |-> ##2 serial_ctrl_b_o == $past(wr_data_i, 2))
        else $error("control b mirror wrong");
    a_addr_held:
    assert property (addr_wr_i |-> ##2 own_addr_or_reload_o == $past(wr_data_i, 2))
        else $error("address mirror wrong");
    a_status_upper_rw:
    assert property (status_wr_i |-> ##2
        serial_status_reg_o[7:6] == $past(wr_data_i[7:6], 2))
        else $error("status upper bits wrong");
    a_buffer_load:
    assert property (buffer_wr_i |-> ##2
        serial_byte_buffer_o == $past(wr_data_i, 2))
        else $error("buffer not loaded");
    a_irq_sticky:
    assert property ($fell(serial_irq_flag_o) |->
        ($past(irq_clr_i) || $past(irq_clr_i, 2)))
        else $error("interrupt flag dropped alone");
    a_clock_half_min:
    assert property ($changed(bus_clock_pin_oe_o) |=> $stable(bus_clock_pin_oe_o))
        else $error("clock half period too short");
endmodule
bind two_wire_port two_wire_port_assertions i_chk (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .wr_data_i(wr_data_i),
    .ctrl_a_wr_i(ctrl_a_wr_i), .ctrl_b_wr_i(ctrl_b_wr_i),
    .status_wr_i(status_wr_i), .buffer_wr_i(buffer_wr_i),
    .addr_wr_i(addr_wr_i), .irq_clr_i(irq_clr_i),
    .serial_ctrl_a_o(serial_ctrl_a_o), .serial_ctrl_b_o(serial_ctrl_b_o),
    .serial_status_reg_o(serial_status_reg_o),
    .serial_byte_buffer_o(serial_byte_buffer_o),
    .own_addr_or_reload_o(own_addr_or_reload_o),
    .serial_irq_flag_o(serial_irq_flag_o), .bus_clock_pin_o(bus_clock_pin_o),
    .bus_clock_pin_oe_o(bus_clock_pin_oe_o), .bus_data_pin_o(bus_data_pin_o)
);

// ===== bench/bus_slave_model.sv
// Bus slave model that records one byte and acknowledges it
`timescale 1ns/1ps
module bus_slave_model (
    // Bus wires and control
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic       ack_en_i,
    // Pull-low enable and captured byte
    output logic            sda_oe_o,
    output logic      [7:0] byte_o
);
    int unsigned bit_cnt = 9;
    initial begin
        sda_oe_o = 1'b0;
        byte_o   = 8'h00;
    end
    always @(negedge sda_i) begin
        #1;
        if (scl_i) begin
            bit_cnt = 0;
        end
    end
    always @(posedge scl_i) begin
        if (bit_cnt < 8) begin
            byte_o = {byte_o[6:0], sda_i};
        end
        bit_cnt = bit_cnt + 1;
    end
    always @(negedge scl_i) begin
        sda_oe_o <= ack_en_i && (bit_cnt == 8);
    end
endmodule

// ===== bench/two_wire_port_test.sv
// Self-checking bench for the two-wire port
`timescale 1ns/1ps
module two_wire_port_test;
    logic       sys_clk, reset, buffer_rd, irq_clr, ack_en, ack, irq;
    logic       tb_scl_oe, tb_sda_oe, scl, sda, scl_oe, sda_oe, scl_o, sda_o;
    logic       model_oe;
    logic [4:0] strb;
    logic [7:0] wr_data, d, a, r, ctrl_a, ctrl_b, stat, bufv, addr, rx_byte;
    logic [7:0] hdr [5];
    int         n_errors, tests_run, cycles, n;
    assign scl = ~(scl_oe | tb_scl_oe);
    assign sda = ~(sda_oe | tb_sda_oe | model_oe);
    two_wire_port i_dut (
        .sys_clk_i(sys_clk), .reset_i(reset), .wr_data_i(wr_data),
        .ctrl_a_wr_i(strb[0]), .ctrl_b_wr_i(strb[1]), .status_wr_i(strb[2]),
        .buffer_wr_i(strb[3]), .addr_wr_i(strb[4]), .buffer_rd_i(buffer_rd),
        .irq_clr_i(irq_clr), .serial_ctrl_a_o(ctrl_a),
        .serial_ctrl_b_o(ctrl_b), .serial_status_reg_o(stat),
        .serial_byte_buffer_o(bufv), .own_addr_or_reload_o(addr),
        .serial_irq_flag_o(irq), .bus_clock_pin_i(scl),
        .bus_clock_pin_o(scl_o), .bus_clock_pin_oe_o(scl_oe),
        .bus_data_pin_i(sda), .bus_data_pin_o(sda_o),
        .bus_data_pin_oe_o(sda_oe)
    );
    bus_slave_model i_slave (
        .scl_i(scl), .sda_i(sda), .ack_en_i(ack_en), .sda_oe_o(model_oe),
        .byte_o(rx_byte)
    );
    task automatic final_report();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input int s, input logic [7:0] v);
        strb    = 5'h01 << s;
        wr_data = v;
        @(negedge sys_clk);
        strb = 5'h00;
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic half();
        repeat (8) @(negedge sys_clk);
    endtask
    task automatic clr();
        {buffer_rd, irq_clr} = 2'h3;
        @(negedge sys_clk);
        {buffer_rd, irq_clr} = 2'h0;
        repeat (2) @(negedge sys_clk);
        chk("flags cleared", 8'h00, {7'h00, irq} | (stat & 8'h01));
    endtask
    task automatic send(input logic [7:0] b);
        for (int k = 0; k < 9; k++) begin
            tb_sda_oe = ~b[7];
            b         = {b[6:0], 1'b1};
            half();
            tb_scl_oe = 1'b0;
            half();
            ack       = sda_oe;
            tb_scl_oe = 1'b1;
        end
    endtask
    task automatic frame(input logic [7:0] b);
        tb_sda_oe = 1'b1;
        half();
        tb_scl_oe = 1'b1;
        send(b);
    endtask
    task automatic stop_f();
        tb_sda_oe = 1'b1;
        half();
        tb_scl_oe = 1'b0;
        half();
        tb_sda_oe = 1'b0;
        half();
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        {strb, wr_data, buffer_rd, irq_clr, ack_en, tb_scl_oe, tb_sda_oe} = '0;
        reset = 1'b1;
        void'($urandom(11));
        repeat (10) @(negedge sys_clk);
        reset = 1'b0;
        chk("reset", 8'h00, ctrl_a | ctrl_b | stat | bufv | addr | 8'(irq));
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            wr(0, d);
            chk("ctrl_a", d, ctrl_a);
            wr(1, d & 8'hFA);
            chk("ctrl_b", d & 8'hFA, ctrl_b);
            wr(4, d);
            chk("addr", d, addr);
            wr(2, d);
            chk("status", d & 8'hC0, stat);
        end
        wr(2, 8'h00);
        wr(0, 8'h20);
        a   = 8'($urandom_range(8'h77, 8'h08));
        wr(4, {a[6:0], 1'b0});
        hdr = '{{a[6:0], 1'b0}, {a[6:0], 1'b1} ^ 8'h03, 8'h00, 8'h00,
                {5'h1E, a[1:0], 1'b0}};
        for (int c = 0; c < 5; c++) begin
            wr(1, (c == 3) ? 8'h80 : 8'h00);
            frame(hdr[c]);
            chk("slave ack", 8'(5'h19 >> c) & 8'h01, 8'(ack));
            if (c == 0) begin
                d = 8'($urandom);
                send(d);
                chk("data ack", 8'h01, 8'(ack));
                chk("rx buffer", d, bufv);
                chk("rx flags", 8'h03, {6'h00, irq, stat[0]});
            end
            stop_f();
            chk("stop seen", 8'h10, stat & 8'h10);
            clr();
        end
        ack_en = 1'b1;
        for (int c = 0; c < 3; c++) begin
            r = (c == 0) ? 8'h00 : 8'($urandom_range(6, 1));
            d = 8'($urandom);
            wr(0, 8'h28);
            wr(4, r);
            wr(3, d);
            chk("tx buffer", d, bufv);
            chk("busy", 8'h04, stat & 8'h04);
            while (!scl_oe) @(negedge sys_clk);
            while (scl_oe) @(negedge sys_clk);
            for (n = 0; !scl_oe; n++) @(negedge sys_clk);
            chk("half period", 8'((r + 1) * 2), 8'(n));
            clr();
            while (!irq) @(negedge sys_clk);
            repeat (2) @(negedge sys_clk);
            chk("tx byte", d, rx_byte);
            chk("pins idle", 8'h00, {6'h00, scl_oe, sda_oe});
            clr();
        end
        final_report();
    end
endmodule
